// [bench/sram_host_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
module sram_host_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_lane,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic retain_ready,
  input wire logic [`ADDR_W-1:0] sram_addr,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic upper_lane_n,
  input wire logic lower_lane_n,
  input wire logic [`DATA_W-1:0] sram_dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_write_qual: assert property (!write_n |-> !chip_sel_n && !(upper_lane_n && lower_lane_n))
    else $error("write strobe without select or lane");
  a_write_len: assert property ($fell(write_n) |-> !write_n [*2] ##1 write_n)
    else $error("write pulse length wrong");
  a_data_hold: assert property ($rose(write_n) |-> |sram_dq_oe)
    else $error("data released at write end");
  a_write_oe_high: assert property (!write_n |-> out_en_n)
    else $error("output enable low in write");
  a_cs_we_rise: assert property ($rose(write_n) |-> $rose(chip_sel_n))
    else $error("select and strobe not rising together");
  a_drive_oe_off: assert property (|sram_dq_oe |-> out_en_n)
    else $error("host drives bus while device may drive");
  a_read_we_high: assert property (!out_en_n && !chip_sel_n |-> write_n)
    else $error("strobe low during read");
  a_addr_stable: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(sram_addr))
    else $error("address moved during access");
  property p_read_lat;
    req_valid && req_ready && !req_write && req_lane != 2'b00 |-> ##7 rsp_valid;
  endproperty
  a_read_lat: assert property (p_read_lat)
    else $error("read answer late");
  a_retain_desel: assert property (retain_ready |-> chip_sel_n)
    else $error("selected in retention");
  a_recover: assert property ($fell(retain_ready) |-> !req_ready [*3])
    else $error("access too soon after retention");
  c_write: cover property ($rose(write_n));
  c_read: cover property (rsp_valid);
  c_retain: cover property ($fell(retain_ready));
endmodule
bind sram_host sram_host_sva u_sva (.*);
`default_nettype wire

// [bench/sram_host_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t mismatch", $time); end end
module sram_host_tb_top;
  logic clk = 0, rst = 1, vld = 0, wr = 0, ret = 0, rdy, rv, rr, cs, we, oe, ub, lb;
  logic [16:0] addr = 0, sa;
  logic [15:0] wd = 0, rd, dq_in, dq_out, dq_oe;
  logic [1:0] lane = 0;
  int error_cnt = 0, n_compared = 0, n;
  sram_host u_dut (.clk(clk), .rst(rst), .ce(1'b1), .req_valid(vld), .req_write(wr),
    .req_addr(addr), .req_wdata(wd), .req_lane(lane), .req_ready(rdy), .rsp_valid(rv),
    .rsp_rdata(rd), .retain_req(ret), .retain_ready(rr), .sram_addr(sa), .chip_sel_n(cs),
    .write_n(we), .out_en_n(oe), .upper_lane_n(ub), .lower_lane_n(lb), .sram_dq_in(dq_in),
    .sram_dq_out(dq_out), .sram_dq_oe(dq_oe));
  sram_model #(.DLY(40)) u_mem (.a(sa), .cs_n(cs), .we_n(we), .oe_n(oe), .ub_n(ub),
    .lb_n(lb), .hd(dq_out), .hoe(dq_oe), .dq(dq_in));
  initial forever #12.5 clk = ~clk;
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task op(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] l);
    @(posedge clk);
    vld <= 1; wr <= w; addr <= a; wd <= d; lane <= l;
    @(negedge clk);
    for (n = 0; n < 50 && rdy !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    vld <= 0;
  endtask
  task rd_chk(input logic [16:0] a, input logic [1:0] l, input logic [15:0] e);
    op(0, a, 16'h0000, l);
    for (n = 0; n < 20 && rv !== 1'b1; n++) @(negedge clk);
    `CHK(rv, 1'b1)
    `CHK(rd, e)
  endtask
  task t_lanes;
    op(1, 17'h1ffff, 16'ha5c3, 2'h3);
    rd_chk(17'h1ffff, 2'h3, 16'ha5c3);
    op(1, 17'h1ffff, 16'h1234, 2'h1);
    rd_chk(17'h1ffff, 2'h3, 16'ha534);
    rd_chk(17'h1ffff, 2'h2, 16'ha500);
    $display("lanes done");
  endtask
  task t_refuse;
    op(1, 17'h00000, 16'hffff, 2'h0);
    repeat (8) begin
      @(negedge clk);
      `CHK(cs, 1'b1)
    end
    $display("refuse done");
  endtask
  task t_retain;
    @(posedge clk) ret <= 1;
    for (n = 0; n < 20 && rr !== 1'b1; n++) @(negedge clk);
    `CHK(cs, 1'b1)
    @(posedge clk) ret <= 0;
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(negedge clk);
    `CHK(n >= `READ_CYC, 1'b1)
    $display("retain done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_lanes;
    t_refuse;
    t_retain;
    report_and_stop;
  end
  initial begin
    #100us;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// [bench/sram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
  parameter DLY = 0
) (
  input wire logic [16:0] a,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic ub_n,
  input wire logic lb_n,
  input wire logic [15:0] hd,
  input wire logic [15:0] hoe,
  output wire logic [15:0] dq
);
  logic [15:0] mem [0:131071];
  wire wr = !cs_n && !we_n;
  wire [15:0] en;
  assign en = (!cs_n && we_n && !oe_n) ? {{8{!ub_n}}, {8{!lb_n}}} : 16'h0000;
  // write strobe low or select rising with it keeps the device side quiet
  always @* begin
    if (wr && !lb_n) mem[a][7:0] = hd[7:0];
    if (wr && !ub_n) mem[a][15:8] = hd[15:8];
  end
  // released lanes show the inverse, not a held value
  // old word lingers for the whole delay after an address change
  assign #(DLY) dq = (hoe & hd) | (~hoe & en & mem[a]) |
    (~hoe & ~en & ~mem[a]);
endmodule
`default_nettype wire

// [hw/pin_sync.v]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// [hw/sram_host.v]
// Behaviour
// - write only with select, strobe, lane low
// - write ends when any qualifier rises
// - data held past the write-ending edge
// - host drives data from the strobe-falling edge, with output enable high
// - strobe stays high during every read
// - address valid before select falls for writes, set on the same edge for reads
// - deselect before retention entry
// - wait one read cycle after retention
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
module sram_host (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire req_valid,
  input wire req_write,
  input wire [`ADDR_W-1:0] req_addr,
  input wire [`DATA_W-1:0] req_wdata,
  input wire [1:0] req_lane,
  output wire req_ready,
  output reg rsp_valid,
  output reg [`DATA_W-1:0] rsp_rdata,
  input wire retain_req,
  output wire retain_ready,
  output reg [`ADDR_W-1:0] sram_addr,
  output reg chip_sel_n,
  output reg write_n,
  output reg out_en_n,
  output reg upper_lane_n,
  output reg lower_lane_n,
  input wire [`DATA_W-1:0] sram_dq_in,
  output reg [`DATA_W-1:0] sram_dq_out,
  output reg [`DATA_W-1:0] sram_dq_oe
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam IDLE = 3'd0;
  localparam RD = 3'd1;
  localparam WR_SETUP = 3'd2;
  localparam WR = 3'd3;
  localparam WR_HOLD = 3'd4;
  localparam RETAIN = 3'd5;
  localparam RECOVER = 3'd6;
  localparam TURN = 3'd7;

  localparam integer READ_I = `READ_CYC;
  localparam integer WRITE_I = `WRITE_CYC;
  localparam integer TURN_I = `TURN_CYC;
  localparam integer RECOVER_I = `RECOVER_CYC;
  localparam [`CNT_W-1:0] READ_CNT = READ_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] WRITE_CNT = WRITE_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] TURN_CNT = TURN_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RECOVER_CNT = RECOVER_I[`CNT_W-1:0];

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CNT_W-1:0] cnt;
  reg [`CNT_W-1:0] next_cnt;
  reg [1:0] lane;
  wire [`DATA_W-1:0] dq_sync;

  // ----------------------------------------
  // data pins from outside pass two flops
  // ----------------------------------------
  pin_sync #(.W(`DATA_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(sram_dq_in),
    .q(dq_sync)
  );

  assign req_ready = (state == IDLE) && !retain_req;
  assign retain_ready = (state == RETAIN);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_cnt = (cnt == {`CNT_W{1'b0}}) ? cnt : cnt - {{(`CNT_W-1){1'b0}}, 1'b1};
    case (state)
      IDLE: begin
        if (retain_req) begin
          next_state = RETAIN;
        end else if (req_valid && req_lane != 2'b00) begin
          next_state = req_write ? WR_SETUP : RD;
          // read counts the read cycle time plus the two sync flops
          next_cnt = req_write ? WRITE_CNT : READ_CNT + 4'd2;
        end
      end
      RD: begin
        if (cnt == {`CNT_W{1'b0}}) begin
          next_state = TURN;
          next_cnt = TURN_CNT;
        end
      end
      WR_SETUP: next_state = WR;
      WR: begin
        if (cnt == {`CNT_W{1'b0}}) begin
          next_state = WR_HOLD;
        end
      end
      WR_HOLD: begin
        next_state = TURN;
        next_cnt = TURN_CNT;
      end
      TURN: begin
        if (cnt == {`CNT_W{1'b0}}) begin
          next_state = IDLE;
        end
      end
      RETAIN: begin
        if (!retain_req) begin
          next_state = RECOVER;
          next_cnt = RECOVER_CNT;
        end
      end
      RECOVER: begin
        if (cnt == {`CNT_W{1'b0}}) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // ----------------------------------------
  // pins and response
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= IDLE;
      cnt <= {`CNT_W{1'b0}};
      lane <= 2'b00;
      sram_addr <= {`ADDR_W{1'b0}};
      chip_sel_n <= 1'b1;
      write_n <= 1'b1;
      out_en_n <= 1'b1;
      upper_lane_n <= 1'b1;
      lower_lane_n <= 1'b1;
      sram_dq_out <= {`DATA_W{1'b0}};
      sram_dq_oe <= {`DATA_W{1'b0}};
      rsp_valid <= 1'b0;
      rsp_rdata <= {`DATA_W{1'b0}};
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      rsp_valid <= 1'b0;
      case (next_state)
        RD: begin
          if (state == IDLE) begin
            sram_addr <= req_addr;
            lane <= req_lane;
          end
          chip_sel_n <= 1'b0;
          write_n <= 1'b1;
          out_en_n <= 1'b0;
          upper_lane_n <= (state == IDLE) ? ~req_lane[1] : ~lane[1];
          lower_lane_n <= (state == IDLE) ? ~req_lane[0] : ~lane[0];
        end
        WR_SETUP: begin
          sram_addr <= req_addr;
          lane <= req_lane;
          out_en_n <= 1'b1;
          write_n <= 1'b1;
          chip_sel_n <= 1'b1;
          sram_dq_out <= req_wdata;
        end
        WR: begin
          chip_sel_n <= 1'b0;
          write_n <= 1'b0;
          upper_lane_n <= ~lane[1];
          lower_lane_n <= ~lane[0];
          sram_dq_oe <= {{8{lane[1]}}, {8{lane[0]}}};
        end
        WR_HOLD: begin
          // select and strobe rise on one edge, data held one more cycle
          chip_sel_n <= 1'b1;
          write_n <= 1'b1;
          upper_lane_n <= 1'b1;
          lower_lane_n <= 1'b1;
        end
        default: begin
          chip_sel_n <= 1'b1;
          write_n <= 1'b1;
          out_en_n <= 1'b1;
          upper_lane_n <= 1'b1;
          lower_lane_n <= 1'b1;
          sram_dq_oe <= {`DATA_W{1'b0}};
        end
      endcase
      if (state == RD && next_state == TURN) begin
        rsp_valid <= 1'b1;
        // disabled lanes read as zero; late sample covers hold
        rsp_rdata <= dq_sync & {{8{lane[1]}}, {8{lane[0]}}};
      end
    end
  end
endmodule
`default_nettype wire

// [pkg/sram_host_regs.vh]
`ifndef SRAM_HOST_REGS_VH
`define SRAM_HOST_REGS_VH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define ADDR_W 17
`define DATA_W 16
// ----------------------------------------
// timing in ns (faster grade) and clock period
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define READ_CYCLE_PERIOD_NS 55
`define ADDR_TO_DATA_DELAY_NS 55
`define WE_PULSE_NS 40
`define BW_PULSE_NS 50
`define DATA_SETUP_NS 25
`define OUT_DISABLE_NS 20
`define DESELECT_BEFORE_RETENTION_NS 0
// ----------------------------------------
// cycle counts: least times round up, at least one
// ----------------------------------------
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC ((`CYC_UP(`READ_CYCLE_PERIOD_NS) < 1) ? 1 : `CYC_UP(`READ_CYCLE_PERIOD_NS))
`define WRITE_CYC ((`CYC_UP(`BW_PULSE_NS) < 1) ? 1 : `CYC_UP(`BW_PULSE_NS))
`define TURN_CYC ((`CYC_UP(`OUT_DISABLE_NS) < 1) ? 1 : `CYC_UP(`OUT_DISABLE_NS))
`define RECOVER_CYC `READ_CYC
`define CNT_W 4
`endif
